//--- rtl/bwoc_pkg.sv
// shared constants for the bit window output control block
// assumes a single 25 MHz clock and an AXI4-Lite register bus
package bwoc_pkg;
    // -------------------------------------------------------
    // clock and serial timing
    // -------------------------------------------------------
    localparam int unsigned CLK_HZ = 25_000_000;
    localparam int unsigned BAUD_RATE = 9600;
    localparam logic [15:0] BAUD_DIV_RST = 16'(CLK_HZ / BAUD_RATE);
    localparam logic [4:0] FRAME_LAST = 5'h1D;

    // -------------------------------------------------------
    // register byte addresses
    // -------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_BAUD = 8'h04;
    localparam logic [7:0] ADDR_TEMP_INT = 8'h08;
    localparam logic [7:0] ADDR_TEMP_TOP = 8'h0C;
    localparam logic [7:0] ADDR_FMT_MASK = 8'h10;
    localparam logic [7:0] ADDR_STRAT_SEL = 8'h14;
    localparam logic [7:0] ADDR_STRAT_A = 8'h18;
    localparam logic [7:0] ADDR_STRAT_B = 8'h1C;
    localparam logic [7:0] ADDR_STATUS = 8'h20;
    localparam logic [7:0] ADDR_HITS = 8'h24;

    // -------------------------------------------------------
    // field positions and reset values
    // -------------------------------------------------------
    localparam int CTRL_TAG_LSB = 4;
    localparam int TEMP_MIN_LSB = 8;
    localparam int STRAT_DIG_BIT = 1;
    localparam int STRAT_OUT_LSB = 4;
    localparam int STRAT_ID_LSB = 8;
    localparam int STRAT_HI_LSB = 16;
    localparam logic [3:0] POL_RST = 4'hF;
    localparam logic signed [7:0] TEMP_MAX_RST = 8'h55;
    localparam logic signed [7:0] TEMP_MIN_RST = 8'hD8;
    localparam logic [15:0] FMT_MASK_RST = 16'h5A5A;
    localparam logic [15:0] LIM_LO_RST = 16'h0CCD;
    localparam logic [15:0] LIM_HI_RST = 16'hF333;

    localparam int N_STRAT = 32;
    localparam int REC_W = 24;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        TAG_HIGH = 2'h0,
        TAG_LOW = 2'h1,
        TAG_MICRO = 2'h2
    } bwoc_tag_e;
endpackage : bwoc_pkg

//--- rtl/bwoc_rec_if.sv
// error record stream between the monitor, its buffer and the serialiser
// assumes all parties run on the same clock
`timescale 1ns/10ps
`default_nettype none
interface bwoc_rec_if;
    logic valid;
    logic ready;
    logic [bwoc_pkg::REC_W-1:0] data;
    modport src(output valid, output data, input ready);
    modport dst(input valid, input data, output ready);
endinterface : bwoc_rec_if
`default_nettype wire

//--- rtl/bwoc_buf.sv
// two-entry record buffer with valid/ready on both sides
// assumes one clock; a stalled drain fills it and drops ready upstream
`timescale 1ns/10ps
`default_nettype none
module bwoc_buf (
    input wire logic clk,
    input wire logic rst_b,
    bwoc_rec_if.dst fill,
    bwoc_rec_if.src drain
);
    logic [bwoc_pkg::REC_W-1:0] mem [2];
    logic [1:0] count;
    logic wrPtr;
    logic rdPtr;
    logic push;
    logic pop;

    assign fill.ready = (count != 2'h2);
    assign drain.valid = (count != 2'h0);
    assign drain.data = mem[rdPtr];
    assign push = fill.valid && fill.ready;
    assign pop = drain.valid && drain.ready;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            count <= 2'h0;
            wrPtr <= 1'b0;
            rdPtr <= 1'b0;
        end else begin
            count <= count + {1'b0, push} - {1'b0, pop};
            if (push) begin
                wrPtr <= !wrPtr;
            end
            if (pop) begin
                rdPtr <= !rdPtr;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wrPtr] <= fill.data;
        end
    end
endmodule : bwoc_buf
`default_nettype wire

//--- rtl/bwoc_ser.sv
// serial error stream: three 8N1 bytes per record, code first
// assumes a baud divisor of at least 2; pad makes it differential
`timescale 1ns/10ps
`default_nettype none
module bwoc_ser (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [15:0] baudDiv,
    bwoc_rec_if.dst rec,
    output logic txd
);
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_SEND = 2'b10
    } bwoc_ser_e;

    bwoc_ser_e state;
    logic [15:0] baudCnt;
    logic [4:0] bitCnt;
    logic [28:0] shift;
    logic tick;

    assign rec.ready = (state == ST_IDLE);
    assign tick = (baudCnt >= baudDiv - 16'h0001);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            baudCnt <= 16'h0000;
        end else if (state == ST_IDLE || tick) begin
            baudCnt <= 16'h0000;
        end else begin
            baudCnt <= baudCnt + 16'h0001;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= ST_IDLE;
            txd <= 1'b1;
            bitCnt <= 5'h00;
            shift <= '0;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    if (rec.valid) begin
                        state <= ST_SEND;
                        txd <= 1'b0;
                        bitCnt <= 5'h00;
                        shift <= {1'b1, rec.data[7:0], 1'b0,
                            1'b1, rec.data[15:8], 1'b0,
                            1'b1, rec.data[23:16]};
                    end
                end
                ST_SEND: begin
                    if (tick) begin
                        if (bitCnt == bwoc_pkg::FRAME_LAST) begin
                            state <= ST_IDLE;
                            txd <= 1'b1;
                        end else begin
                            txd <= shift[0];
                            shift <= {1'b1, shift[28:1]};
                            bitCnt <= bitCnt + 5'h01;
                        end
                    end
                end
            endcase
        end
    end
endmodule : bwoc_ser
`default_nettype wire

//--- rtl/bwoc_top.sv
// window monitor with four indicator channels and a serial error stream
// assumes backplane samples, times and temperatures arrive on clk
//
// Behaviour
// - four output channels, each usable as LED, dolls eye or TTL.
// - each channel has its own active level and drives it when on.
// - errors leave as a serial stream at a programmable baud rate.
// - the record time tag is the high word, low word or microseconds.
// - internal and top-block temperatures are checked on own limits.
// - the active backplane format is checked against an allowed mask.
// - any active window function with an output enabled turns all four channels on.
// - an analog function fires when the count leaves its limits.
// - analog counts are unsigned 16-bit offset binary.
// - 32 strategies, several of which may watch the same parameter.
// - a digital function fires when masked bits equal the pattern.
//
// Chosen here: the register offsets and register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
module bwoc_top (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic sampleValid,
    input wire logic [7:0] sampleId,
    input wire logic [15:0] sampleData,
    input wire logic [15:0] timeHigh,
    input wire logic [15:0] timeLow,
    input wire logic [15:0] timeMicro,
    input wire logic signed [7:0] tempInternal,
    input wire logic signed [7:0] tempTopBlock,
    input wire logic [3:0] fmtActive,
    output logic [3:0] chanOut,
    output logic serialTx
);
    // -------------------------------------------------------
    // configuration state
    // -------------------------------------------------------
    logic [3:0] polarity;
    logic [1:0] tagSel;
    logic [15:0] baudDiv;
    logic signed [7:0] tIntMax, tIntMin, tTopMax, tTopMin;
    logic [15:0] fmtMask;
    logic [4:0] stratSel;
    logic stratEn [bwoc_pkg::N_STRAT];
    logic stratDig [bwoc_pkg::N_STRAT];
    logic [3:0] stratOut [bwoc_pkg::N_STRAT];
    logic [7:0] stratId [bwoc_pkg::N_STRAT];
    logic [15:0] stratLo [bwoc_pkg::N_STRAT];
    logic [15:0] stratHi [bwoc_pkg::N_STRAT];
    logic [31:0] hit;
    logic tIntErr, tTopErr, fmtErr;
    logic anyActive;

    // -------------------------------------------------------
    // helpers
    // -------------------------------------------------------
    function automatic logic [31:0] mergeStrb(input logic [31:0] old,
        input logic [31:0] nw, input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return r;
    endfunction : mergeStrb

    // unsigned compare: offset binary keeps zero input at mid scale
    function automatic logic windowHit(input logic dig,
        input logic [15:0] lo, input logic [15:0] hi,
        input logic [15:0] v);
        if (dig) begin
            return (v & lo) == (hi & lo);
        end
        return (v < lo) || (v > hi);
    endfunction : windowHit

    function automatic logic addrOk(input logic [7:0] a);
        return (a[1:0] == 2'h0) && (a <= bwoc_pkg::ADDR_HITS);
    endfunction : addrOk

    function automatic logic [31:0] regRead(input logic [7:0] a);
        logic [31:0] r;
        r = '0;
        case (a)
            bwoc_pkg::ADDR_CTRL: r = {26'h0, tagSel, polarity};
            bwoc_pkg::ADDR_BAUD: r = {16'h0, baudDiv};
            bwoc_pkg::ADDR_TEMP_INT: r = {16'h0, tIntMin, tIntMax};
            bwoc_pkg::ADDR_TEMP_TOP: r = {16'h0, tTopMin, tTopMax};
            bwoc_pkg::ADDR_FMT_MASK: r = {16'h0, fmtMask};
            bwoc_pkg::ADDR_STRAT_SEL: r = {27'h0, stratSel};
            bwoc_pkg::ADDR_STRAT_A: r = {16'h0, stratId[stratSel],
                stratOut[stratSel], 2'h0, stratDig[stratSel],
                stratEn[stratSel]};
            bwoc_pkg::ADDR_STRAT_B: r = {stratHi[stratSel],
                stratLo[stratSel]};
            bwoc_pkg::ADDR_STATUS: r = {24'h0, fmtErr, tTopErr, tIntErr,
                anyActive, chanOut};
            bwoc_pkg::ADDR_HITS: r = hit;
            default: r = '0;
        endcase
        return r;
    endfunction : regRead

    // -------------------------------------------------------
    // AXI4-Lite slave
    // -------------------------------------------------------
    logic awHave, wHave, wrDo;
    logic [7:0] awAddr;
    logic [31:0] wData, wrVal;
    logic [3:0] wStrb;

    assign s_axi_awready = !awHave && !s_axi_bvalid;
    assign s_axi_wready = !wHave && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign wrDo = awHave && wHave && !s_axi_bvalid;

    // always_comb also wakes on the state that regRead reads inside
    always_comb begin
        wrVal = mergeStrb(regRead(awAddr), wData, wStrb);
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            awHave <= 1'b0;
            wHave <= 1'b0;
            awAddr <= 8'h00;
            wData <= 32'h0000_0000;
            wStrb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= bwoc_pkg::RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHave <= 1'b1;
                awAddr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHave <= 1'b1;
                wData <= s_axi_wdata;
                wStrb <= s_axi_wstrb;
            end
            if (wrDo) begin
                awHave <= 1'b0;
                wHave <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= addrOk(awAddr) ? bwoc_pkg::RESP_OKAY
                    : bwoc_pkg::RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= bwoc_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= regRead(s_axi_araddr);
            s_axi_rresp <= addrOk(s_axi_araddr) ? bwoc_pkg::RESP_OKAY
                : bwoc_pkg::RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // -------------------------------------------------------
    // global setup registers
    // -------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            polarity <= bwoc_pkg::POL_RST;
            tagSel <= bwoc_pkg::TAG_HIGH;
            baudDiv <= bwoc_pkg::BAUD_DIV_RST;
            tIntMax <= bwoc_pkg::TEMP_MAX_RST;
            tIntMin <= bwoc_pkg::TEMP_MIN_RST;
            tTopMax <= bwoc_pkg::TEMP_MAX_RST;
            tTopMin <= bwoc_pkg::TEMP_MIN_RST;
            fmtMask <= bwoc_pkg::FMT_MASK_RST;
            stratSel <= 5'h00;
        end else if (wrDo) begin
            case (awAddr)
                bwoc_pkg::ADDR_CTRL: begin
                    polarity <= wrVal[3:0];
                    tagSel <= wrVal[bwoc_pkg::CTRL_TAG_LSB +: 2];
                end
                bwoc_pkg::ADDR_BAUD: baudDiv <= wrVal[15:0];
                bwoc_pkg::ADDR_TEMP_INT: begin
                    tIntMax <= wrVal[7:0];
                    tIntMin <= wrVal[bwoc_pkg::TEMP_MIN_LSB +: 8];
                end
                bwoc_pkg::ADDR_TEMP_TOP: begin
                    tTopMax <= wrVal[7:0];
                    tTopMin <= wrVal[bwoc_pkg::TEMP_MIN_LSB +: 8];
                end
                bwoc_pkg::ADDR_FMT_MASK: fmtMask <= wrVal[15:0];
                bwoc_pkg::ADDR_STRAT_SEL: stratSel <= wrVal[4:0];
                default: ;
            endcase
        end
    end

    // -------------------------------------------------------
    // strategy table, written through the select register
    // -------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int s = 0; s < bwoc_pkg::N_STRAT; s++) begin
                stratEn[s] <= 1'b0;
                stratDig[s] <= 1'b0;
                stratOut[s] <= 4'h0;
                stratId[s] <= 8'h00;
                stratLo[s] <= bwoc_pkg::LIM_LO_RST;
                stratHi[s] <= bwoc_pkg::LIM_HI_RST;
            end
        end else if (wrDo && awAddr == bwoc_pkg::ADDR_STRAT_A) begin
            stratEn[stratSel] <= wrVal[0];
            stratDig[stratSel] <= wrVal[bwoc_pkg::STRAT_DIG_BIT];
            stratOut[stratSel] <= wrVal[bwoc_pkg::STRAT_OUT_LSB +: 4];
            stratId[stratSel] <= wrVal[bwoc_pkg::STRAT_ID_LSB +: 8];
        end else if (wrDo && awAddr == bwoc_pkg::ADDR_STRAT_B) begin
            stratLo[stratSel] <= wrVal[15:0];
            stratHi[stratSel] <= wrVal[bwoc_pkg::STRAT_HI_LSB +: 16];
        end
    end

    // -------------------------------------------------------
    // window evaluation; each enabled strategy judges only samples with its own id
    // -------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            hit <= 32'h0000_0000;
        end else begin
            for (int s = 0; s < bwoc_pkg::N_STRAT; s++) begin
                if (!stratEn[s]) begin
                    hit[s] <= 1'b0;
                end else if (sampleValid && stratId[s] == sampleId) begin
                    hit[s] <= windowHit(stratDig[s], stratLo[s],
                        stratHi[s], sampleData);
                end
            end
        end
    end

    // a strategy with no outputs enabled is watched but lights nothing
    always_comb begin
        anyActive = 1'b0;
        for (int s = 0; s < bwoc_pkg::N_STRAT; s++) begin
            anyActive = anyActive || (hit[s] && stratOut[s] != 4'h0);
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            chanOut <= 4'h0;
        end else begin
            chanOut <= anyActive ? polarity : ~polarity;
        end
    end

    // -------------------------------------------------------
    // temperature and format checks
    // -------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tIntErr <= 1'b0;
            tTopErr <= 1'b0;
            fmtErr <= 1'b0;
        end else begin
            tIntErr <= tempInternal > tIntMax
                || tempInternal < tIntMin;
            tTopErr <= tempTopBlock > tTopMax
                || tempTopBlock < tTopMin;
            fmtErr <= !fmtMask[fmtActive];
        end
    end

    // -------------------------------------------------------
    // error records: a new event is never lost to a push
    // -------------------------------------------------------
    bwoc_rec_if pushIf ();
    bwoc_rec_if txIf ();
    logic [3:0] evNow, evPrev, pend, pick;
    logic [15:0] tag;

    assign evNow = {fmtErr, tTopErr, tIntErr, anyActive};
    assign pick = pend & (~pend + 4'h1);
    assign pushIf.valid = (pend != 4'h0);
    assign pushIf.data = {4'h0, pick, tag};

    always_comb begin
        unique case (tagSel)
            bwoc_pkg::TAG_HIGH: tag = timeHigh;
            bwoc_pkg::TAG_LOW: tag = timeLow;
            default: tag = timeMicro;
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            evPrev <= 4'h0;
            pend <= 4'h0;
        end else begin
            evPrev <= evNow;
            pend <= (pend & ~(pushIf.ready ? pick : 4'h0))
                | (evNow & ~evPrev);
        end
    end

    bwoc_buf u_buf (
        .clk(clk),
        .rst_b(rst_b),
        .fill(pushIf.dst),
        .drain(txIf.src)
    );

    bwoc_ser u_ser (
        .clk(clk),
        .rst_b(rst_b),
        .baudDiv(baudDiv),
        .rec(txIf.dst),
        .txd(serialTx)
    );

    // -------------------------------------------------------
    // assertions
    // -------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    property p_all_on;
        anyActive |=> chanOut == $past(polarity);
    endproperty
    a_all_on: assert property (p_all_on) else $error("chan off");

    property p_off_level;
        !anyActive |=> chanOut == ~$past(polarity);
    endproperty
    a_off_level: assert property (p_off_level) else $error("idle");

    property p_analog;
        sampleValid && stratEn[0] && !stratDig[0] && stratId[0] == sampleId
            && sampleData > stratHi[0] |=> hit[0];
    endproperty
    a_analog: assert property (p_analog) else $error("analog miss");

    property p_digital;
        sampleValid && stratEn[1] && stratDig[1] && stratId[1] == sampleId
            && ((sampleData ^ stratHi[1]) & stratLo[1]) != 16'h0000
            |=> !hit[1];
    endproperty
    a_digital: assert property (p_digital) else $error("mask bad");

    property p_release;
        hit == 32'h0000_0000 ##1 $stable(polarity)
            |-> chanOut == ~polarity;
    endproperty
    a_release: assert property (p_release) else $error("stuck on");

    property p_temp;
        tempInternal > tIntMax |=> tIntErr;
    endproperty
    a_temp: assert property (p_temp) else $error("temp missed");

    property p_fmt;
        !fmtMask[fmtActive] && $stable(fmtMask) |=> fmtErr;
    endproperty
    a_fmt: assert property (p_fmt) else $error("format missed");

    property p_tag;
        pushIf.valid && tagSel == bwoc_pkg::TAG_LOW
            |-> pushIf.data[15:0] == timeLow;
    endproperty
    a_tag: assert property (p_tag) else $error("bad tag");

    property p_event_kept;
        evNow[0] && !evPrev[0] |=> pend[0];
    endproperty
    a_event_kept: assert property (p_event_kept) else $error("lost");

    property p_bhold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
    endproperty
    a_bhold: assert property (p_bhold) else $error("bvalid dropped");

    c_active: cover property (anyActive ##1 chanOut == polarity);
    c_record: cover property (pushIf.valid && pushIf.ready);
    c_full: cover property (!pushIf.ready);
    c_release: cover property (anyActive ##[1:50] !anyActive);
endmodule : bwoc_top
`default_nettype wire

//--- test/bwoc_rx_model.sv
// listener on the serial error stream: 8N1 frames into 9-bit words
// assumes the same baud divisor as the block; bit 8 is the stop bit
`timescale 1ns/10ps
`default_nettype none
module bwoc_rx_model (
    input wire logic clk,
    input wire logic rxd,
    input wire logic [15:0] div,
    output logic got,
    output logic [8:0] frame
);
    // sample mid-bit so edge jitter of the line never matters
    always begin
        got <= 1'b0;
        @(negedge rxd);
        repeat (div / 2) @(posedge clk);
        for (int i = 0; i < 9; i++) begin
            repeat (div) @(posedge clk);
            frame[i] <= rxd;
        end
        got <= 1'b1;
        @(posedge clk);
    end
endmodule : bwoc_rx_model
`default_nettype wire

//--- test/bwoc_tb_top.sv
// self-checking bench for the window monitor block
// assumes the serial listener model and a baud divisor of 4
`timescale 1ns/10ps
`default_nettype none
module bwoc_tb_top;
    logic clk = 1'b0, rst_b = 1'b0, got;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, sampleId = 8'h00;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, sampleValid = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF, fmtActive = 4'h1, chanOut;
    logic [15:0] sampleData = 16'h0000, timeHigh = 16'hA5C3;
    logic [15:0] timeLow = 16'h3C5A, timeMicro = 16'h1234;
    logic signed [7:0] tempInternal = 8'sd25, tempTopBlock = 8'sd25;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, serialTx;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [8:0] frame;
    logic [33:0] qr[$];
    logic [8:0] qs[$];
    logic [31:0] lfsr = 32'hb782_9ac7;
    int miscompares = 0, total_checks = 0;

    always #20 clk = ~clk;
    bwoc_top uut (.*);
    bwoc_rx_model rx (.clk(clk), .rxd(serialTx), .div(16'h0004),
        .got(got), .frame(frame));

    function automatic logic [31:0] nxt(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : nxt
    task automatic chk(input string n, input logic [33:0] e, s);
        total_checks++;
        if (e !== s) begin
            $display("[ERR] %s exp %h got %h", n, e, s);
            miscompares++;
        end
    endtask : chk
    task automatic end_of_test;
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : end_of_test
    // results are settled mid-cycle; one negedge per handshake
    always @(negedge clk) begin
        if (s_axi_rvalid && s_axi_rready) chk("rd", qr.pop_front(),
            {s_axi_rresp, s_axi_rdata});
        if (got) chk("ser", qs.pop_front(), frame);
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
        input logic [1:0] r);
        logic aw = 1'b0, w = 1'b0;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw && w)) begin
            @(negedge clk);
            aw = aw | (s_axi_awready & s_axi_awvalid);
            w = w | (s_axi_wready & s_axi_wvalid);
            @(posedge clk);
            if (aw) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
        end
        do @(negedge clk); while (!s_axi_bvalid);
        chk("bresp", r, s_axi_bresp);
        @(posedge clk);
        s_axi_bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        qr.push_back(e);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(negedge clk); while (!s_axi_arready);
        @(posedge clk);
        s_axi_arvalid <= 1'b0;
        do @(negedge clk); while (!s_axi_rvalid);
        @(posedge clk);
        s_axi_rready <= 1'b0;
    endtask : rd
    task automatic smp(input logic [7:0] id, input logic [15:0] v,
        input logic [3:0] e);
        @(posedge clk);
        sampleValid <= 1'b1;
        sampleId <= id;
        sampleData <= v;
        @(posedge clk);
        sampleValid <= 1'b0;
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk("chan", e, chanOut);
    endtask : smp
    task automatic ex3(input logic [7:0] c, input logic [15:0] t);
        qs.push_back({1'b1, c});
        qs.push_back({1'b1, t[15:8]});
        qs.push_back({1'b1, t[7:0]});
    endtask : ex3
    task automatic dr;
        while (qs.size() != 0) @(posedge clk);
    endtask : dr

    initial begin
        repeat (5000) @(posedge clk);
        miscompares++;
        end_of_test();
    end
    initial begin
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        rd(8'h00, {2'h0, 32'h0000_000F});
        rd(8'h04, {2'h0, 32'h0000_0A2C});
        rd(8'h08, {2'h0, 32'h0000_D855});
        rd(8'h0C, {2'h0, 32'h0000_D855});
        rd(8'h10, {2'h0, 32'h0000_5A5A});
        rd(8'h28, {2'h2, 32'h0000_0000});
        wr(8'h28, 32'h0000_0000, 2'h2);
        $display("test reset done");
        wr(8'h04, 32'h0000_0004, 2'h0);
        wr(8'h18, 32'h0000_0311, 2'h0);
        smp(8'h03, 16'h8000, 4'h0);
        for (int i = 0; i < 4; i++) begin
            lfsr = nxt(lfsr);
            smp(8'h03, 16'h4000 | {1'b0, lfsr[14:0]}, 4'h0);
        end
        ex3(8'h01, timeHigh);
        smp(8'h03, 16'h0CCC, 4'hF);
        smp(8'h03, 16'h0CCD, 4'h0);
        dr();
        ex3(8'h01, timeHigh);
        smp(8'h03, 16'hF334, 4'hF);
        smp(8'h03, 16'hF333, 4'h0);
        dr();
        $display("test analog done");
        wr(8'h00, 32'h0000_0015, 2'h0);
        ex3(8'h01, timeLow);
        smp(8'h03, 16'h0000, 4'h5);
        rd(8'h20, {2'h0, 32'h0000_0015});
        smp(8'h03, 16'h8000, 4'hA);
        dr();
        wr(8'h14, 32'h0000_0001, 2'h0);
        wr(8'h1C, 32'h8000_8000, 2'h0);
        wr(8'h18, 32'h0000_0713, 2'h0);
        ex3(8'h01, timeLow);
        smp(8'h07, 16'h8001, 4'h5);
        smp(8'h07, 16'h7FFF, 4'hA);
        dr();
        $display("test digital done");
        wr(8'h00, 32'h0000_0025, 2'h0);
        ex3(8'h02, timeMicro);
        @(posedge clk);
        tempInternal <= 8'sd86;
        rd(8'h20, {2'h0, 32'h0000_002A});
        ex3(8'h04, timeMicro);
        ex3(8'h08, timeMicro);
        tempInternal <= 8'sd25;
        tempTopBlock <= 8'hD7;
        fmtActive <= 4'h0;
        rd(8'h20, {2'h0, 32'h0000_00CA});
        dr();
        $display("test status done");
        end_of_test();
    end
endmodule : bwoc_tb_top
`default_nettype wire
